// file: design/daot_dev.sv
// converter end: divider, pipeline, data clock, wake-up, sync and serial port
// Function
// [RULE_01] single-ended mode: samples appear 12 conversions later
// [RULE_02] differential: A at 12, B at 12.5; code drops B at divide 1 and 2 (B step off, or lost to the A tick)
// [RULE_03] 500 us wake-up; data invalid meanwhile
// [RULE_04] conversion rate from input clock, divide 1..8
// [RULE_05] data clock delay in register 0x17 bits 0-4
// [RULE_06] sync sampled on rising input clock edge
// [RULE_07] serial bits captured on rising serial clock
// [RULE_08] read: drive after fall, release after rise
// [RULE_09] capture discards words before pipeline latency elapses
`timescale 1ns/1ns
module daot_dev
  import daot_pkg::*;
#(
  parameter int WAKE_CYC = WAKE_LNK_CYC
) (
  input  wire logic          lnk_clk,
  input  wire logic          resetn,
  daot_if.dev                bus,
  input  wire logic [DW-1:0] ain_a,
  input  wire logic [DW-1:0] ain_b,
  output logic               sample_strobe,
  output logic               running
);
  localparam logic [4:0] PIN_RST = 5'b11000;

  logic [4:0]       pin_in;
  logic [4:0]       s1_q;
  logic [4:0]       s2_q;
  logic [4:0]       s3_q;
  logic [4:0]       stb_q;
  logic [4:0]       prv_q;
  logic             sync_rise;
  logic             sclk_rise;
  logic             sclk_fall;
  logic             csn;
  logic             sdi;
  logic [4:0]       bcnt_q;
  logic [15:0]      ins_q;
  logic [7:0]       wsh_q;
  logic             wr_go;
  logic [7:0]       rbyte;
  logic [4:0]       ridx;
  logic             sdo_q;
  logic             sdo_oe_q;
  logic [DIV_W-1:0] div_q;
  logic             diff_q;
  logic [DCO_W-1:0] dly_q;
  daot_pw_e         pw_q;
  logic [31:0]      wk_q;
  logic             run;
  logic [DIV_W-1:0] dcnt_q;
  logic [DIV_W-1:0] mid_pt;
  logic             tick;
  logic             mid;
  logic [DW-1:0]    pa [LAT];
  logic [DW-1:0]    pb [LAT];
  logic [DW-1:0]    out_a_q;
  logic [DW-1:0]    out_b_q;
  logic [DW-1:0]    bh_q;
  logic             dcor_q;
  logic [31:0]      dline_q;
  logic             dco_q;

  //////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  assign pin_in = {bus.sdio, bus.chip_select_n, bus.sclk, bus.pdwn, bus.sync};

  always_ff @(posedge lnk_clk or negedge resetn) begin
    if (!resetn) begin
      s1_q  <= PIN_RST;
      s2_q  <= PIN_RST;
      s3_q  <= PIN_RST;
      stb_q <= PIN_RST;
      prv_q <= PIN_RST;
    end else begin
      s1_q  <= pin_in;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      stb_q <= (s2_q & ~(s2_q ^ s3_q)) | (stb_q & (s2_q ^ s3_q)); // [RULE_06]
      prv_q <= stb_q;
    end
  end

  assign sync_rise = stb_q[0] & ~prv_q[0]; // [RULE_06]
  assign sclk_rise = stb_q[2] & ~prv_q[2];
  assign sclk_fall = ~stb_q[2] & prv_q[2];
  assign csn       = stb_q[3];
  assign sdi       = stb_q[4];

  //////////////////////////////////////////////////////////////////////////
  // serial port
  always_ff @(posedge lnk_clk or negedge resetn) begin
    if (!resetn) begin
      bcnt_q <= 5'h00;
      ins_q  <= 16'h0000;
      wsh_q  <= 8'h00;
    end else if (csn) begin
      bcnt_q <= 5'h00;
    end else if (sclk_rise && bcnt_q < 5'(FRM_BITS)) begin
      bcnt_q <= bcnt_q + 5'h01;
      if (bcnt_q < 5'(INS_BITS)) begin
        ins_q <= {ins_q[14:0], sdi}; // [RULE_07]
      end else begin
        wsh_q <= {wsh_q[6:0], sdi}; // [RULE_07]
      end
    end
  end

  assign wr_go = ~csn & sclk_rise & (bcnt_q == 5'(FRM_BITS - 1)) & ~ins_q[RD_BIT];

  always_ff @(posedge lnk_clk or negedge resetn) begin
    if (!resetn) begin
      div_q  <= DIV_RST;
      diff_q <= MODE_RST;
      dly_q  <= DCO_RST;
    end else if (wr_go) begin
      case (ins_q[12:0])
        REG_DIV:  div_q  <= {wsh_q[DIV_W-2:0], sdi}; // [RULE_04]
        REG_MODE: diff_q <= sdi;
        REG_DCO:  dly_q  <= {wsh_q[DCO_LSB+3:DCO_LSB], sdi}; // [RULE_05]
        default:  ;
      endcase
    end
  end

  always_comb begin
    case (ins_q[12:0])
      REG_DIV:  rbyte = {5'h00, div_q};
      REG_MODE: rbyte = {7'h00, diff_q};
      REG_DCO:  rbyte = {3'h0, dly_q};
      default:  rbyte = 8'h00;
    endcase
  end

  assign ridx = 5'(FRM_BITS - 1) - bcnt_q;

  always_ff @(posedge lnk_clk or negedge resetn) begin
    if (!resetn) begin
      sdo_q    <= 1'b0;
      sdo_oe_q <= 1'b0;
    end else if (csn) begin
      sdo_oe_q <= 1'b0;
    end else if (sclk_fall && ins_q[RD_BIT] && bcnt_q >= 5'(INS_BITS)
                 && bcnt_q < 5'(FRM_BITS)) begin
      sdo_oe_q <= 1'b1; // [RULE_08]
      sdo_q    <= rbyte[ridx[2:0]];
    end else if (sclk_rise && bcnt_q == 5'(FRM_BITS - 1)) begin
      sdo_oe_q <= 1'b0; // [RULE_08]
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // power-down and wake-up
  always_ff @(posedge lnk_clk or negedge resetn) begin
    if (!resetn) begin
      pw_q <= PW_RUN;
      wk_q <= 32'h0;
    end else if (stb_q[1]) begin
      pw_q <= PW_DOWN;
      wk_q <= 32'h0;
    end else begin
      case (pw_q)
        PW_DOWN: pw_q <= PW_WAKE;
        PW_WAKE: begin
          if (wk_q == 32'(WAKE_CYC - 1)) begin
            pw_q <= PW_RUN; // [RULE_03]
          end else begin
            wk_q <= wk_q + 32'h1;
          end
        end
        PW_RUN:  pw_q <= PW_RUN;
        default: pw_q <= PW_DOWN;
      endcase
    end
  end

  assign run = pw_q == PW_RUN;

  //////////////////////////////////////////////////////////////////////////
  // clock divider
  always_ff @(posedge lnk_clk or negedge resetn) begin
    if (!resetn) begin
      dcnt_q <= 3'h0;
    end else if (sync_rise || !run || dcnt_q == div_q) begin
      dcnt_q <= 3'h0; // [RULE_04]
    end else begin
      dcnt_q <= dcnt_q + 3'h1;
    end
  end

  assign mid_pt = 3'((4'(div_q) + 4'h1) >> 1);
  assign tick   = run & ~sync_rise & (dcnt_q == div_q); // [RULE_04]
  assign mid    = run & (div_q != 3'h0) & (dcnt_q == mid_pt);

  //////////////////////////////////////////////////////////////////////////
  // sample pipeline
  always_ff @(posedge lnk_clk) begin
    if (tick) begin
      pa[0] <= ain_a;
      pb[0] <= ain_b;
    end
  end

  for (genvar i = 1; i < LAT; i++) begin : g_pipe
    always_ff @(posedge lnk_clk) begin
      if (tick) begin
        pa[i] <= pa[i-1];
        pb[i] <= pb[i-1];
      end
    end
  end

  always_ff @(posedge lnk_clk or negedge resetn) begin
    if (!resetn) begin
      out_a_q <= '0;
      out_b_q <= '0;
      bh_q    <= '0;
      dcor_q  <= 1'b0;
    end else if (!run) begin
      out_a_q <= '0; // [RULE_03]
      out_b_q <= '0;
      dcor_q  <= 1'b0;
    end else if (tick) begin
      out_a_q <= pa[LAT-1]; // [RULE_01] [RULE_02]
      out_b_q <= diff_q ? '0 : pb[LAT-1]; // [RULE_01]
      bh_q    <= pb[LAT-1];
      dcor_q  <= 1'b1;
    end else if (mid) begin
      dcor_q <= 1'b0;
      if (diff_q) begin
        out_a_q <= bh_q; // [RULE_02]
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // data clock delay line and outputs
  always_ff @(posedge lnk_clk or negedge resetn) begin
    if (!resetn) begin
      dline_q       <= 32'h0;
      dco_q         <= 1'b0;
      sample_strobe <= 1'b0;
      running       <= 1'b0;
    end else begin
      dline_q       <= {dline_q[30:0], dcor_q};
      dco_q         <= dline_q[dly_q]; // [RULE_05]
      sample_strobe <= tick;
      running       <= run;
    end
  end

  assign bus.data_a         = out_a_q;
  assign bus.data_b         = out_b_q;
  assign bus.data_clock_out = dco_q;
  assign bus.sdio_d_o       = sdo_q;
  assign bus.sdio_d_oe      = sdo_oe_q;
endmodule : daot_dev

// file: design/daot_pkg.sv
// shared constants and types for the converter output timing pair
package daot_pkg;
  localparam int          DW          = 16;
  localparam int          LAT         = 12;
  localparam int          DIV_W       = 3;
  localparam int          DCO_LSB     = 0;
  localparam int          DCO_W       = 5;
  localparam logic [12:0] REG_DIV     = 13'h00B;
  localparam logic [12:0] REG_MODE    = 13'h014;
  localparam logic [12:0] REG_DCO     = 13'h017;
  localparam logic [2:0]  DIV_RST     = 3'h0;
  localparam logic        MODE_RST    = 1'b0;
  localparam logic [4:0]  DCO_RST     = 5'h00;
  localparam int          INS_BITS    = 16;
  localparam int          FRM_BITS    = 24;
  localparam int          RD_BIT      = 15;
  localparam int          WAKE_US     = 500;
  localparam int          SYS_MHZ     = 250;
  localparam int          LNK_PER_PS  = 6000;
  localparam int          WAKE_SYS_CYC = WAKE_US * SYS_MHZ;
  localparam int          WAKE_LNK_CYC = WAKE_US * 1000000 / LNK_PER_PS;
  localparam int          SCLK_PER_NS = 64;
  localparam int          SCLK_HALF   = (SCLK_PER_NS * SYS_MHZ + 1999) / 2000;
  localparam logic [7:0]  H_CMD       = 8'h00;
  localparam logic [7:0]  H_STAT      = 8'h04;
  localparam logic [7:0]  H_CFG       = 8'h08;
  localparam logic [7:0]  H_CAPA      = 8'h0C;
  localparam logic [7:0]  H_CAPB      = 8'h10;
  localparam int          CMD_RD      = 31;
  localparam int          CMD_ADR_LSB = 8;
  localparam int          CFG_PDWN    = 0;
  localparam int          CFG_DIFF    = 1;
  localparam int          CFG_SYNC    = 2;
  localparam logic [2:0]  CFG_RST     = 3'h0;
  typedef enum logic [1:0] {PW_DOWN, PW_WAKE, PW_RUN} daot_pw_e;
  typedef enum logic [1:0] {HS_IDLE, HS_LOW, HS_HIGH, HS_END} daot_hs_e;
endpackage : daot_pkg

// file: design/daot_if.sv
// pins between the converter and its capture and control host
`timescale 1ns/1ns
interface daot_if
  import daot_pkg::*;
();
  logic [DW-1:0] data_a;
  logic [DW-1:0] data_b;
  logic          data_clock_out;
  logic          sync;
  logic          pdwn;
  logic          sclk;
  logic          chip_select_n;
  logic          sdio_h_o;
  logic          sdio_h_oe;
  logic          sdio_d_o;
  logic          sdio_d_oe;
  logic          sdio;

  // shared data line, pulled up when nobody drives
  assign sdio = sdio_d_oe ? sdio_d_o : (sdio_h_oe ? sdio_h_o : 1'b1);

  modport dev (
    output data_a, data_b, data_clock_out, sdio_d_o, sdio_d_oe,
    input  sync, pdwn, sclk, chip_select_n, sdio
  );
  modport host (
    input  data_a, data_b, data_clock_out, sdio,
    output sync, pdwn, sclk, chip_select_n, sdio_h_o, sdio_h_oe
  );
endinterface : daot_if

// file: design/daot_host.sv
// host end: serial port master, power and sync control, word capture
`timescale 1ns/1ns
module daot_host
  import daot_pkg::*;
#(
  parameter int WAKE_CYC = WAKE_SYS_CYC
) (
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  daot_if.host             bus,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic [31:0]      rdata
);
  localparam int         PN      = 2 * DW + 2;
  localparam logic [PN-1:0] PIN_RST = PN'(1);

  logic [PN-1:0] pin_in;
  logic [PN-1:0] s1_q;
  logic [PN-1:0] s2_q;
  logic [PN-1:0] s3_q;
  logic [PN-1:0] stb_q;
  logic          dco_prv_q;
  logic          dco_rise;
  logic          dco_fall;
  logic [DW-1:0] da;
  logic [DW-1:0] db;
  logic [2:0]    cfg_q;
  daot_hs_e      st_q;
  logic [3:0]    tm_q;
  logic [4:0]    bit_q;
  logic [23:0]   frm_q;
  logic          hrd_q;
  logic [7:0]    rx_q;
  logic [7:0]    rdb_q;
  logic          sclk_q;
  logic          csn_q;
  logic          sdo_q;
  logic          oe_q;
  logic          half;
  logic          pd_prv_q;
  logic          waking_q;
  logic [31:0]   wk_q;
  logic [3:0]    wcnt_q;
  logic          valid;
  logic [DW-1:0] capa_q;
  logic [DW-1:0] capb_q;

  //////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  assign pin_in = {bus.data_b, bus.data_a, bus.data_clock_out, bus.sdio};

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      s1_q      <= PIN_RST;
      s2_q      <= PIN_RST;
      s3_q      <= PIN_RST;
      stb_q     <= PIN_RST;
      dco_prv_q <= 1'b0;
    end else begin
      s1_q      <= pin_in;
      s2_q      <= s1_q;
      s3_q      <= s2_q;
      stb_q     <= (s2_q & ~(s2_q ^ s3_q)) | (stb_q & (s2_q ^ s3_q));
      dco_prv_q <= stb_q[1];
    end
  end

  assign dco_rise = stb_q[1] & ~dco_prv_q;
  assign dco_fall = ~stb_q[1] & dco_prv_q;
  assign da       = stb_q[DW+1:2];
  assign db       = stb_q[2*DW+1:DW+2];

  //////////////////////////////////////////////////////////////////////////
  // configuration
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cfg_q <= CFG_RST;
    end else if (wr && addr == H_CFG) begin
      cfg_q <= wdata[2:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // serial port master
  assign half = tm_q == 4'(SCLK_HALF - 1);

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      st_q   <= HS_IDLE;
      tm_q   <= 4'h0;
      bit_q  <= 5'h00;
      frm_q  <= 24'h0;
      hrd_q  <= 1'b0;
      rx_q   <= 8'h00;
      rdb_q  <= 8'h00;
      sclk_q <= 1'b0;
      csn_q  <= 1'b1;
      sdo_q  <= 1'b0;
      oe_q   <= 1'b0;
    end else begin
      tm_q <= half ? 4'h0 : tm_q + 4'h1;
      case (st_q)
        HS_IDLE: begin
          tm_q <= 4'h0;
          if (wr && addr == H_CMD) begin
            frm_q <= {wdata[CMD_RD], 2'b00, wdata[CMD_ADR_LSB+12:CMD_ADR_LSB], wdata[7:0]};
            sdo_q <= wdata[CMD_RD];
            hrd_q <= wdata[CMD_RD];
            bit_q <= 5'h00;
            csn_q <= 1'b0;
            oe_q  <= 1'b1;
            st_q  <= HS_LOW;
          end
        end
        HS_LOW: begin
          if (half) begin
            sclk_q <= 1'b1; // [RULE_07]
            st_q   <= HS_HIGH;
          end
        end
        HS_HIGH: begin
          if (half) begin
            sclk_q <= 1'b0;
            rx_q   <= {rx_q[6:0], stb_q[0]};
            frm_q  <= {frm_q[22:0], 1'b0};
            sdo_q  <= frm_q[22]; // [RULE_07]
            if (bit_q == 5'(FRM_BITS - 1)) begin
              oe_q <= 1'b0;
              st_q <= HS_END;
            end else begin
              bit_q <= bit_q + 5'h01;
              oe_q  <= ~(hrd_q && bit_q >= 5'(INS_BITS - 1)); // [RULE_08]
              st_q  <= HS_LOW;
            end
          end
        end
        HS_END: begin
          if (half) begin
            csn_q <= 1'b1;
            st_q  <= HS_IDLE;
            if (hrd_q) begin
              rdb_q <= rx_q;
            end
          end
        end
        default: st_q <= HS_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // wake-up timer and word capture
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pd_prv_q <= 1'b0;
      waking_q <= 1'b0;
      wk_q     <= 32'h0;
    end else begin
      pd_prv_q <= cfg_q[CFG_PDWN];
      if (pd_prv_q && !cfg_q[CFG_PDWN]) begin
        waking_q <= 1'b1; // [RULE_03]
        wk_q     <= 32'h0;
      end else if (waking_q) begin
        if (wk_q == 32'(WAKE_CYC - 1)) begin
          waking_q <= 1'b0;
        end else begin
          wk_q <= wk_q + 32'h1;
        end
      end
    end
  end

  assign valid = wcnt_q == 4'(LAT);

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      wcnt_q <= 4'h0;
      capa_q <= '0;
      capb_q <= '0;
    end else if (cfg_q[CFG_PDWN] || cfg_q[CFG_SYNC] || waking_q) begin
      wcnt_q <= 4'h0; // [RULE_03] [RULE_09]
    end else begin
      if (dco_rise && !valid) begin
        wcnt_q <= wcnt_q + 4'h1; // [RULE_09]
      end
      if (dco_rise && valid) begin
        capa_q <= da; // [RULE_09]
        if (!cfg_q[CFG_DIFF]) begin
          capb_q <= db;
        end
      end
      if (dco_fall && valid && cfg_q[CFG_DIFF]) begin
        capb_q <= da;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // register read port
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rdata <= 32'h0;
    end else if (rd) begin
      case (addr)
        H_STAT:  rdata <= {16'h0, rdb_q, 5'h00, waking_q, valid, st_q != HS_IDLE};
        H_CFG:   rdata <= {29'h0, cfg_q};
        H_CAPA:  rdata <= {16'h0, capa_q};
        H_CAPB:  rdata <= {16'h0, capb_q};
        default: rdata <= 32'h0;
      endcase
    end else begin
      rdata <= 32'h0;
    end
  end

  assign bus.sync          = cfg_q[CFG_SYNC]; // [RULE_06]
  assign bus.pdwn          = cfg_q[CFG_PDWN];
  assign bus.sclk          = sclk_q;
  assign bus.chip_select_n = csn_q;
  assign bus.sdio_h_o      = sdo_q;
  assign bus.sdio_h_oe     = oe_q;
endmodule : daot_host

// file: tb/daot_chk.sv
// assertion checker on the pins between the converter and its host
`timescale 1ns/1ns
module daot_chk
  import daot_pkg::*;
(
  input wire logic          clk_sys,
  input wire logic          lnk_clk,
  input wire logic          resetn,
  input wire logic [DW-1:0] data_a,
  input wire logic          data_clock_out,
  input wire logic          pdwn,
  input wire logic          sclk,
  input wire logic          chip_select_n,
  input wire logic          sdio_h_o,
  input wire logic          sdio_h_oe,
  input wire logic          sdio_d_oe
);
  ////////////////////////////////////////////////////////////////////////////////
  one_driver_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    !(sdio_d_oe && sdio_h_oe)) else $error("sdio driven by both ends");
  dev_turn_a: assert property (@(posedge lnk_clk) disable iff (!resetn)
    $rose(sdio_d_oe) |-> !$past(sclk, 2) && !chip_select_n)
    else $error("device drive not after fall");
  sdo_steady_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    $rose(sclk) && sdio_h_oe |-> $stable(sdio_h_o) ##1 $stable(sdio_h_o))
    else $error("host data moved at serial rise");
  sclk_high_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    $rose(sclk) |-> sclk [*8]) else $error("serial clock high too short");
  sclk_low_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    $fell(sclk) |-> !sclk [*8]) else $error("serial clock low too short");
  cs_setup_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    $fell(chip_select_n) |-> !sclk [*4]) else $error("select too close to serial rise");
  sclk_idle_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    chip_select_n |-> !sclk) else $error("serial clock outside frame");
  pdwn_quiet_a: assert property (@(posedge lnk_clk) disable iff (!resetn)
    pdwn [*8] |-> ##2 data_a == '0 && !data_clock_out) else $error("output during power down");
  wake_bound_a: assert property (@(posedge lnk_clk) disable iff (!resetn)
    $fell(pdwn) |-> ##[1:300] data_clock_out) else $error("no data clock after wake");
endmodule : daot_chk

// file: tb/dual_adc_output_timing_tb.sv
// self-checking bench for the converter and host pair
`timescale 1ns/1ns
module dual_adc_output_timing_tb
  import daot_pkg::*;
();
  logic            clk_sys, lnk_clk, resetn, wr, rd, frz, chk_en, dmode, dco_p;
  logic [7:0]      addr, b8, v;
  logic [31:0]     wdata, rdata, s, a1;
  logic [DW-1:0]   ain_a, ain_b, va, vb;
  logic            sample_strobe, running;
  logic [31:0]     hq[$];
  integer          seed;
  int              err_count, n_checks, ratio, c, off, o0, n_strb, k;

  daot_if u_daot_if ();
  daot_dev #(.WAKE_CYC(20)) u_daot_dev (.lnk_clk(lnk_clk), .resetn(resetn), .bus(u_daot_if),
    .ain_a(ain_a), .ain_b(ain_b), .sample_strobe(sample_strobe), .running(running));
  daot_host #(.WAKE_CYC(20)) u_daot_host (.clk_sys(clk_sys), .resetn(resetn), .bus(u_daot_if),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
  daot_chk u_daot_chk (.clk_sys(clk_sys), .lnk_clk(lnk_clk), .resetn(resetn),
    .data_a(u_daot_if.data_a), .data_clock_out(u_daot_if.data_clock_out),
    .pdwn(u_daot_if.pdwn), .sclk(u_daot_if.sclk), .chip_select_n(u_daot_if.chip_select_n),
    .sdio_h_o(u_daot_if.sdio_h_o), .sdio_h_oe(u_daot_if.sdio_h_oe),
    .sdio_d_oe(u_daot_if.sdio_d_oe));

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  initial begin
    // odd-ns edges never meet a system clock edge
    lnk_clk = 1'b0;
    forever #3 lnk_clk = ~lnk_clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic summarize();
    if (err_count == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : summarize

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk_sys);
    wr    <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] q);
    @(posedge clk_sys);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk_sys);
    rd   <= 1'b0;
    @(negedge clk_sys);
    q = rdata;
  endtask : rd_reg

  task automatic spi(input logic rdf, input logic [12:0] da, input logic [7:0] db);
    wr_reg(H_CMD, {rdf, 10'h000, da, db});
    repeat (2) @(posedge clk_sys);
    s = 32'h1;
    for (int i = 0; i < 400 && s[0] !== 1'b0; i++) rd_reg(H_STAT, s);
    if (s[0] !== 1'b0) begin
      err_count++;
      summarize();
    end
    b8 = s[15:8];
  endtask : spi

  task automatic spi_chk(input logic [12:0] da, input logic [7:0] e);
    spi(1'b1, da, 8'h00);
    chk("device reg", e, b8);
  endtask : spi_chk

  task automatic window();
    repeat (40) @(posedge clk_sys);
    chk_en = 1'b1;
    repeat (300) @(posedge clk_sys);
    chk_en = 1'b0;
  endtask : window

  task automatic cap_chk();
    frz = 1'b1;
    va = DW'($random(seed));
    vb = DW'($random(seed));
    ain_a <= va;
    ain_b <= vb;
    repeat (400) @(posedge clk_sys);
    rd_reg(H_STAT, s);
    chk("capture valid", 1, s[1]);
    rd_reg(H_CAPA, s);
    chk("capture a", va, s[15:0]);
    rd_reg(H_CAPB, s);
    chk("capture b", vb, s[15:0]);
    frz = 1'b0;
  endtask : cap_chk

  ////////////////////////////////////////////////////////////////////////////////
  // link side model: sample history, latency, divider spacing, data clock offset
  always @(posedge lnk_clk) begin
    c = c + 1;
    if (u_daot_if.data_clock_out && !dco_p) off = c;
    dco_p = u_daot_if.data_clock_out;
    if (sample_strobe) begin
      n_strb++;
      hq.push_back(a1);
      k = hq.size() - 13;
      if (chk_en && hq.size() > 1) chk("strobe gap", ratio, c);
      if (chk_en && k >= 0) begin
        chk("data a", hq[k][15:0], u_daot_if.data_a);
        chk("data b", dmode ? 32'h0 : hq[k][31:16], u_daot_if.data_b);
      end
      c = 0;
    end
    if (!chk_en) hq.delete();
    a1 = {ain_b, ain_a};
    if (!frz) begin
      ain_a <= DW'($random(seed));
      ain_b <= DW'($random(seed));
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 32'h319B;
    {addr, wdata, wr, rd, frz, chk_en, dmode, dco_p} = '0;
    {ain_a, ain_b, a1} = '0;
    {err_count, n_checks, c, off, n_strb} = '0;
    resetn = 1'b0;
    repeat (8) @(posedge clk_sys);
    resetn <= 1'b1;
    rd_reg(H_CFG, s);
    chk("host cfg", CFG_RST, s);
    rd_reg(8'h1C, s);
    chk("host unmapped", 0, s);
    spi_chk(REG_DIV, DIV_RST);
    spi_chk(REG_MODE, MODE_RST);
    spi_chk(REG_DCO, DCO_RST);
    spi_chk(13'h001, 8'h00);
    for (int r = 0; r < 8; r++) begin
      v = 8'($random(seed));
      spi(1'b0, REG_DIV, {v[7:3], 3'(r)});
      spi_chk(REG_DIV, 8'(r));
      ratio = r + 1;
      window();
    end
    o0 = off;
    v = 8'($random(seed));
    spi(1'b0, REG_DCO, v);
    spi_chk(REG_DCO, {3'h0, v[4:0]});
    window();
    chk("dco step", v[2:0], 3'(off - o0));
    spi(1'b0, REG_DCO, 8'h00);
    cap_chk();
    spi(1'b0, REG_MODE, 8'h01);
    wr_reg(H_CFG, 32'h2);
    dmode = 1'b1;
    window();
    cap_chk();
    wr_reg(H_CFG, 32'h3);
    repeat (50) @(posedge clk_sys);
    k = n_strb;
    repeat (100) @(posedge clk_sys);
    chk("pdwn strobes", k, n_strb);
    chk("pdwn running", 0, running);
    rd_reg(H_STAT, s);
    chk("pdwn valid", 0, s[1]);
    wr_reg(H_CFG, 32'h2);
    for (int i = 0; i < 300 && running !== 1'b1; i++) @(posedge clk_sys);
    chk("wake running", 1, running);
    cap_chk();
    wr_reg(H_CFG, 32'h6);
    repeat (20) @(posedge clk_sys);
    wr_reg(H_CFG, 32'h2);
    window();
    cap_chk();
    summarize();
  end
endmodule : dual_adc_output_timing_tb
